// ---- hdl/ars_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ars_top (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // Protection and breaker pins
    input wire ars_pkg::ars_pins_type PINS_IN,
    // Breaker and event outputs
    output logic CLOSE_CMD_OUT,
    output logic DYN_BLOCK_OUT,
    output logic IRQ_OUT,
    // AXI4-Lite write channels
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // AXI4-Lite read channels
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN
);
    import ars_pkg::*;

    // Pin synchronisers and trip edge
    ars_pins_type sync1_reg, sync2_reg;
    logic trip_prev_reg;
    logic trip_rise;

    // Sequencer state
    ars_state_type state_reg, state_next;
    logic prog_reg, prog_next;
    logic [3:0] shot_reg, shot_next;
    logic [ARS_TW-1:0] tmr_reg, tmr_next;
    logic [ARS_TW-1:0] close_tmr_reg, close_tmr_next;
    logic close_reg, close_next;
    logic dyn_reg, dyn_next;
    logic ev_close, ev_reset, ev_block;

    // Register file and bus state
    logic [2:0] ctrl_reg, ctrl_next;
    logic [7:0] shots_reg, shots_next;
    logic [ARS_IRQ_W-1:0] irq_stat_reg, irq_stat_next;
    logic [ARS_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
    logic irq_reg, irq_next;
    logic [ARS_TW-1:0] trest_reg, trest_next;
    logic [ARS_TW-1:0] tclose_reg, tclose_next;
    logic [ARS_TW-1:0] tblk_reg, tblk_next;
    logic [ARS_TW-1:0] dead_reg [8];
    logic [ARS_TW-1:0] dead_next [8];
    logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic bvalid_reg, bvalid_next, arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;

    // Helpers for the sequencer
    logic brk_open, gnd_fault;
    logic [3:0] max_shots;
    logic [1:0] dead_idx;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // Two flops before any logic sees a pin
    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            trip_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= PINS_IN;
            sync2_reg <= sync1_reg;
            trip_prev_reg <= sync2_reg.trip_init;
        end
    end
    assign trip_rise = sync2_reg.trip_init & ~trip_prev_reg;

    // Program choice, breaker position, dead time slot, shot limit
    always_comb
    begin
        // Any pickup with one phase at most, plus ground or not, picks ground program
        gnd_fault = (|sync2_reg.phase_pu) && (sync2_reg.phase_pu[2:0] == 3'h0 ||
                    sync2_reg.phase_pu[2:0] == 3'h1 || sync2_reg.phase_pu[2:0] == 3'h2 ||
                    sync2_reg.phase_pu[2:0] == 3'h4);
        // Contacts when wired, otherwise pickup dropout
        unique case ({ctrl_reg[ARS_CTRL_AUXB_BIT], ctrl_reg[ARS_CTRL_AUXA_BIT]})
            2'h3: brk_open = ~sync2_reg.aux_a & sync2_reg.aux_b;
            2'h2: brk_open = sync2_reg.aux_b;
            2'h1: brk_open = ~sync2_reg.aux_a;
            2'h0: brk_open = ~sync2_reg.pickup_gen;
        endcase
        // Shots past the fourth share the fourth slot
        dead_idx = (shot_reg >= 4'h3) ? 2'h3 : shot_reg[1:0];
        max_shots = prog_reg ? shots_reg[7:4] : shots_reg[3:0];
        if (max_shots > ARS_MAX_SHOTS)
        begin
            max_shots = ARS_MAX_SHOTS;
        end
    end

    // Sequencer next state
    always_comb
    begin
        state_next = state_reg;
        prog_next = prog_reg;
        shot_next = shot_reg;
        tmr_next = tmr_reg;
        close_tmr_next = close_tmr_reg;
        ev_close = 1'b0;
        ev_reset = 1'b0;
        ev_block = 1'b0;
        unique case (state_reg)
            ST_IDLE:
            begin
                shot_next = 4'h0;
                if (trip_rise && ctrl_reg[ARS_CTRL_EN_BIT])
                begin
                    // Zero shots in the chosen program means no start
                    prog_next = gnd_fault;
                    if ((gnd_fault ? shots_reg[7:4] : shots_reg[3:0]) != 4'h0)
                    begin
                        state_next = ST_WAIT_OPEN;
                    end
                end
            end
            ST_WAIT_OPEN:
            begin
                if (brk_open)
                begin
                    tmr_next = dead_reg[{prog_reg, dead_idx}];
                    state_next = ST_DEAD;
                end
            end
            ST_DEAD:
            begin
                tmr_next = tmr_reg - ARS_TW'(1);
                if (tmr_reg <= ARS_TW'(1))
                begin
                    // Close and restraint start together
                    close_tmr_next = tclose_reg;
                    tmr_next = trest_reg;
                    shot_next = shot_reg + 4'h1;
                    ev_close = 1'b1;
                    state_next = ST_RESTRAIN;
                end
            end
            ST_RESTRAIN:
            begin
                if (close_tmr_reg != '0)
                begin
                    close_tmr_next = close_tmr_reg - ARS_TW'(1);
                end
                if (tmr_reg != '0)
                begin
                    tmr_next = tmr_reg - ARS_TW'(1);
                end
                if (sync2_reg.pickup_init)
                begin
                    tmr_next = trest_reg;
                end
                if (trip_rise)
                begin
                    close_tmr_next = '0;
                    if (shot_reg < max_shots)
                    begin
                        // Failed shot: restraint cancelled, next cycle
                        tmr_next = '0;
                        state_next = ST_WAIT_OPEN;
                    end
                    else
                    begin
                        tmr_next = tblk_reg;
                        ev_block = 1'b1;
                        state_next = ST_DYNBLK;
                    end
                end
                else if (tmr_reg <= ARS_TW'(1) && !sync2_reg.pickup_init && close_tmr_reg <= ARS_TW'(1))
                begin
                    // Restraint only ends once the close pulse is over
                    shot_next = 4'h0;
                    ev_reset = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_DYNBLK:
            begin
                tmr_next = tmr_reg - ARS_TW'(1);
                if (tmr_reg <= ARS_TW'(1))
                begin
                    // Trip or pickup still present keeps the block
                    if (sync2_reg.trip_init || sync2_reg.pickup_gen)
                    begin
                        tmr_next = tblk_reg;
                    end
                    else
                    begin
                        shot_next = 4'h0;
                        state_next = ST_IDLE;
                    end
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        close_next = (close_tmr_next != '0);
        dyn_next = (state_next == ST_DYNBLK);
    end

    // Sequencer registers
    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            state_reg <= ST_IDLE;
            prog_reg <= 1'b0;
            shot_reg <= 4'h0;
            tmr_reg <= '0;
            close_tmr_reg <= '0;
            close_reg <= 1'b0;
            dyn_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            prog_reg <= prog_next;
            shot_reg <= shot_next;
            tmr_reg <= tmr_next;
            close_tmr_reg <= close_tmr_next;
            close_reg <= close_next;
            dyn_reg <= dyn_next;
        end
    end

    // Bus slave, register writes and reads, interrupt status
    always_comb
    begin
        logic [ARS_IRQ_W-1:0] clr;
        clr = '0;
        ctrl_next = ctrl_reg;
        shots_next = shots_reg;
        irq_mask_next = irq_mask_reg;
        trest_next = trest_reg;
        tclose_next = tclose_reg;
        tblk_next = tblk_reg;
        dead_next = dead_reg;
        aw_hold_next = aw_hold_reg;
        w_hold_next = w_hold_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg & ~S_AXI_BREADY_IN;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg & ~S_AXI_RREADY_IN;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        // Address and data are taken in either order
        if (S_AXI_AWVALID_IN && awready_reg)
        begin
            aw_hold_next = 1'b1;
            awaddr_next = S_AXI_AWADDR_IN;
        end
        if (S_AXI_WVALID_IN && wready_reg)
        begin
            w_hold_next = 1'b1;
            wdata_next = S_AXI_WDATA_IN;
            wstrb_next = S_AXI_WSTRB_IN;
        end
        if (aw_hold_reg && w_hold_reg && !bvalid_reg)
        begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = ARS_RESP_OKAY;
            unique case (awaddr_reg)
                ARS_ADDR_CTRL: ctrl_next = 3'(merge(32'(ctrl_reg), wdata_reg, wstrb_reg));
                ARS_ADDR_SHOTS: shots_next = 8'(merge(32'(shots_reg), wdata_reg, wstrb_reg));
                ARS_ADDR_IRQ_STAT: clr = ARS_IRQ_W'(merge(32'h0, wdata_reg, wstrb_reg));
                ARS_ADDR_IRQ_MASK: irq_mask_next = ARS_IRQ_W'(merge(32'(irq_mask_reg), wdata_reg, wstrb_reg));
                ARS_ADDR_T_RESTRAIN: trest_next = ARS_TW'(merge(32'(trest_reg), wdata_reg, wstrb_reg));
                ARS_ADDR_T_MAX_CLOSE: tclose_next = ARS_TW'(merge(32'(tclose_reg), wdata_reg, wstrb_reg));
                ARS_ADDR_T_DYNBLK: tblk_next = ARS_TW'(merge(32'(tblk_reg), wdata_reg, wstrb_reg));
                ARS_ADDR_STATUS: bresp_next = ARS_RESP_SLVERR;
                default:
                begin
                    // Dead time slots: program in bit 4, shot in bits 3:2
                    if (awaddr_reg >= ARS_ADDR_DEAD_BASE && awaddr_reg <= ARS_ADDR_DEAD_LAST &&
                        awaddr_reg[1:0] == 2'h0)
                    begin
                        dead_next[awaddr_reg[4:2]] = ARS_TW'(merge(32'(dead_reg[awaddr_reg[4:2]]),
                                                                     wdata_reg, wstrb_reg));
                    end
                    else
                    begin
                        bresp_next = ARS_RESP_SLVERR;
                    end
                end
            endcase
        end
        // A fresh event outweighs a same-cycle clear
        irq_stat_next = (irq_stat_reg & ~clr) |
                        {ev_block, ev_reset, ev_close};
        irq_next = |(irq_stat_next & irq_mask_next);
        if (S_AXI_ARVALID_IN && arready_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next = ARS_RESP_OKAY;
            unique case (S_AXI_ARADDR_IN)
                ARS_ADDR_CTRL: rdata_next = 32'(ctrl_reg);
                ARS_ADDR_SHOTS: rdata_next = 32'(shots_reg);
                ARS_ADDR_STATUS: rdata_next = 32'({close_reg, dyn_reg, prog_reg, shot_reg, 3'(state_reg)});
                ARS_ADDR_IRQ_STAT: rdata_next = 32'(irq_stat_reg);
                ARS_ADDR_IRQ_MASK: rdata_next = 32'(irq_mask_reg);
                ARS_ADDR_T_RESTRAIN: rdata_next = 32'(trest_reg);
                ARS_ADDR_T_MAX_CLOSE: rdata_next = 32'(tclose_reg);
                ARS_ADDR_T_DYNBLK: rdata_next = 32'(tblk_reg);
                default:
                begin
                    if (S_AXI_ARADDR_IN >= ARS_ADDR_DEAD_BASE && S_AXI_ARADDR_IN <= ARS_ADDR_DEAD_LAST &&
                        S_AXI_ARADDR_IN[1:0] == 2'h0)
                    begin
                        rdata_next = 32'(dead_reg[S_AXI_ARADDR_IN[4:2]]);
                    end
                    else
                    begin
                        rdata_next = 32'h0;
                        rresp_next = ARS_RESP_SLVERR;
                    end
                end
            endcase
        end
        // One transaction in each direction at a time
        awready_next = ~aw_hold_next & ~bvalid_next;
        wready_next = ~w_hold_next & ~bvalid_next;
        arready_next = ~rvalid_next;
    end

    // Bus and register file flops
    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            ctrl_reg <= ARS_CTRL_RST;
            shots_reg <= ARS_SHOTS_RST;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            irq_reg <= 1'b0;
            trest_reg <= ARS_RESTRAIN_RST;
            tclose_reg <= ARS_MAX_CLOSE_RST;
            tblk_reg <= ARS_DYNBLK_RST;
            for (int i = 0; i < 8; i++)
            begin
                dead_reg[i] <= ARS_DEAD_RST;
            end
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= ARS_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= ARS_RESP_OKAY;
            rdata_reg <= 32'h0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            shots_reg <= shots_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg <= irq_next;
            trest_reg <= trest_next;
            tclose_reg <= tclose_next;
            tblk_reg <= tblk_next;
            dead_reg <= dead_next;
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    // Outputs straight from flops
    assign CLOSE_CMD_OUT = close_reg;
    assign DYN_BLOCK_OUT = dyn_reg;
    assign IRQ_OUT = irq_reg;
    assign S_AXI_AWREADY_OUT = awready_reg;
    assign S_AXI_WREADY_OUT = wready_reg;
    assign S_AXI_BVALID_OUT = bvalid_reg;
    assign S_AXI_BRESP_OUT = bresp_reg;
    assign S_AXI_ARREADY_OUT = arready_reg;
    assign S_AXI_RVALID_OUT = rvalid_reg;
    assign S_AXI_RRESP_OUT = rresp_reg;
    assign S_AXI_RDATA_OUT = rdata_reg;
endmodule : ars_top
`default_nettype wire

// ---- inc/ars_pkg.sv ----
`default_nettype none
package ars_pkg;
    // Timing base
    localparam int ARS_CLK_KHZ = 25000;
    localparam int ARS_TW = 28;
    // Register byte offsets
    localparam logic [7:0] ARS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] ARS_ADDR_SHOTS = 8'h04;
    localparam logic [7:0] ARS_ADDR_STATUS = 8'h08;
    localparam logic [7:0] ARS_ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ARS_ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ARS_ADDR_T_RESTRAIN = 8'h14;
    localparam logic [7:0] ARS_ADDR_T_MAX_CLOSE = 8'h18;
    localparam logic [7:0] ARS_ADDR_T_DYNBLK = 8'h1C;
    localparam logic [7:0] ARS_ADDR_DEAD_BASE = 8'h20;
    localparam logic [7:0] ARS_ADDR_DEAD_LAST = 8'h3C;
    // Field positions
    localparam int ARS_CTRL_EN_BIT = 0;
    localparam int ARS_CTRL_AUXA_BIT = 1;
    localparam int ARS_CTRL_AUXB_BIT = 2;
    localparam int ARS_IRQ_CLOSE_BIT = 0;
    localparam int ARS_IRQ_RESET_BIT = 1;
    localparam int ARS_IRQ_BLOCK_BIT = 2;
    localparam int ARS_IRQ_W = 3;
    // Reset values, times in milliseconds
    localparam logic [2:0] ARS_CTRL_RST = 3'h1;
    localparam logic [7:0] ARS_SHOTS_RST = 8'h11;
    localparam logic [3:0] ARS_MAX_SHOTS = 4'h9;
    localparam int ARS_DEAD_MS = 500;
    localparam int ARS_RESTRAIN_MS = 3000;
    localparam int ARS_MAX_CLOSE_MS = 1000;
    localparam int ARS_DYNBLK_MS = 5000;
    localparam logic [ARS_TW-1:0] ARS_DEAD_RST = ARS_TW'(ARS_DEAD_MS * ARS_CLK_KHZ);
    localparam logic [ARS_TW-1:0] ARS_RESTRAIN_RST = ARS_TW'(ARS_RESTRAIN_MS * ARS_CLK_KHZ);
    localparam logic [ARS_TW-1:0] ARS_MAX_CLOSE_RST = ARS_TW'(ARS_MAX_CLOSE_MS * ARS_CLK_KHZ);
    localparam logic [ARS_TW-1:0] ARS_DYNBLK_RST = ARS_TW'(ARS_DYNBLK_MS * ARS_CLK_KHZ);
    // Bus answers
    localparam logic [1:0] ARS_RESP_OKAY = 2'h0;
    localparam logic [1:0] ARS_RESP_SLVERR = 2'h2;

    // Sequencer states
    typedef enum logic [2:0] {ST_IDLE, ST_WAIT_OPEN, ST_DEAD, ST_RESTRAIN, ST_DYNBLK} ars_state_type;

    // Protection and breaker pins; phase_pu[3] is ground, [2:0] phases
    typedef struct packed {
        logic trip_init;
        logic pickup_init;
        logic pickup_gen;
        logic aux_a;
        logic aux_b;
        logic [3:0] phase_pu;
    } ars_pins_type;
endpackage : ars_pkg
`default_nettype wire

// ---- verification/ars_breaker_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ars_breaker_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Commands
    input wire logic trip_in,
    input wire logic close_in,
    // Contacts
    output logic aux_a_out,
    output logic aux_b_out
);
    logic closed_reg;
    logic closed_next;
    // Trip wins over a close still applied
    always_comb closed_next = trip_in ? 1'b0 : (close_in ? 1'b1 : closed_reg);
    // Breaker starts in service
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
            closed_reg <= 1'b1;
        else
            closed_reg <= closed_next;
    assign aux_a_out = closed_reg;
    assign aux_b_out = !closed_reg;
endmodule : ars_breaker_model
`default_nettype wire

// ---- verification/ars_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module ars_sva (
    // Clock, reset and pins
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire ars_pkg::ars_pins_type PINS_IN,
    // Sequencer outputs
    input wire logic CLOSE_CMD_OUT,
    input wire logic DYN_BLOCK_OUT,
    // Bus handshakes
    input wire logic S_AXI_AWREADY_OUT,
    input wire logic S_AXI_WREADY_OUT,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic S_AXI_ARREADY_OUT,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN
);
    import ars_pkg::*;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // Answers stand until taken; no new request taken meanwhile
    b_hold_a:
    assert property ($fell(S_AXI_BVALID_OUT) |-> $past(S_AXI_BREADY_IN)) else $error("write answer dropped");
    b_done_a:
    assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=> !S_AXI_BVALID_OUT && S_AXI_AWREADY_OUT && S_AXI_WREADY_OUT)
        else $error("write channel not freed");
    w_block_a:
    assert property (S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT) else $error("write taken early");
    r_hold_a:
    assert property ($fell(S_AXI_RVALID_OUT) |-> $past(S_AXI_RREADY_IN)) else $error("read answer dropped");
    r_block_a:
    assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT) else $error("read taken early");
    // Pin sync latency allows a few cycles
    close_abort_a:
    assert property (CLOSE_CMD_OUT && $rose(PINS_IN.trip_init) |-> ##[1:6] !CLOSE_CMD_OUT) else $error("close not aborted");
    block_close_a:
    assert property (DYN_BLOCK_OUT |=> !$rose(CLOSE_CMD_OUT)) else $error("close while blocked");
    block_hold_a:
    assert property ((PINS_IN.trip_init || PINS_IN.pickup_gen) [*6] ##0 DYN_BLOCK_OUT |=> DYN_BLOCK_OUT)
        else $error("block left while held");
endmodule : ars_sva
bind ars_top ars_sva i_ars_sva (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .PINS_IN(PINS_IN), .CLOSE_CMD_OUT(CLOSE_CMD_OUT),
    .DYN_BLOCK_OUT(DYN_BLOCK_OUT), .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT), .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
    .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .S_AXI_BREADY_IN(S_AXI_BREADY_IN), .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
    .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN));
`default_nettype wire

// ---- verification/ars_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module ars_top_test;
    import ars_pkg::*;
    logic clk = 1'b0, rst = 1'b1, trip = 1'b0, pui = 1'b0, pug = 1'b0;
    logic [3:0] ph = 4'h0;
    logic aa, ab, close, dyn, irq, awr, wrdy, bv, arr, rv;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [1:0] bresp, rresp;
    ars_pins_type pins;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    int dt [1:6];
    always #20 clk = ~clk;
    assign pins = {trip, pui, pug, aa, ab, ph};
    ars_top i_ars_top (.CLK_IN(clk), .RST_IN(rst), .PINS_IN(pins), .CLOSE_CMD_OUT(close), .DYN_BLOCK_OUT(dyn),
        .IRQ_OUT(irq), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
        .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rready));
    ars_breaker_model i_ars_breaker_model (.clk_in(clk), .rst_in(rst), .trip_in(trip), .close_in(close),
        .aux_a_out(aa), .aux_b_out(ab));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk
    // Address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end
        while ((awv && !awr) || (wv && !wrdy));
        do @(posedge clk); while (!bv);
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        rready <= 1'b0;
        v = rdata;
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    endtask : rd
    // Fault: trip and general pickup, pickup drops once cleared
    task automatic flt();
        @(posedge clk);
        trip <= 1'b1;
        pug <= 1'b1;
        repeat (6) @(posedge clk);
        trip <= 1'b0;
        pug <= 1'b0;
    endtask : flt
    // Cycles until the close command; bounded in case it never comes
    task automatic shot(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!close && n < 2000);
    endtask : shot
    task automatic t_regs();
        rd(ARS_ADDR_CTRL, d, ARS_RESP_OKAY);
        chk("ctrl", d, {29'h0, ARS_CTRL_RST});
        rd(ARS_ADDR_SHOTS, d, ARS_RESP_OKAY);
        chk("shots", d, {24'h0, ARS_SHOTS_RST});
        wr(ARS_ADDR_STATUS, 32'hFF, ARS_RESP_SLVERR);
        rd(8'h40, d, ARS_RESP_SLVERR);
        chk("unmapped", d, 32'h0);
        wr(ARS_ADDR_SHOTS, 32'h1F, ARS_RESP_OKAY);
        rd(ARS_ADDR_SHOTS, d, ARS_RESP_OKAY);
        chk("shots wr", d, 32'h1F);
        wr(ARS_ADDR_SHOTS, 32'h16, ARS_RESP_OKAY);
        wr(ARS_ADDR_T_RESTRAIN, 32'd100, ARS_RESP_OKAY);
        wr(ARS_ADDR_T_MAX_CLOSE, 32'd20, ARS_RESP_OKAY);
        wr(ARS_ADDR_T_DYNBLK, 32'd30, ARS_RESP_OKAY);
        for (int i = 0; i < 8; i++)
            wr(ARS_ADDR_DEAD_BASE + 8'(4 * i), 32'(20 + 8 * i), ARS_RESP_OKAY);
        wr(ARS_ADDR_CTRL, 32'h7, ARS_RESP_OKAY);
        wr(ARS_ADDR_IRQ_MASK, 32'h1, ARS_RESP_OKAY);
        $display("regs done");
    endtask : t_regs
    // Two-phase fault, six shots over contacts, then final trip
    task automatic t_multi();
        ph <= 4'h3;
        for (int k = 1; k <= 6; k++)
        begin
            flt();
            shot(dt[k]);
            rd(ARS_ADDR_STATUS, d, ARS_RESP_OKAY);
            chk("count", {28'h0, d[6:3]}, 32'(k));
            chk("state", {29'h0, d[2:0]}, 32'h3);
            chk("prog", {31'h0, d[7]}, 32'h0);
            chk("dead", 32'(dt[k] - dt[1]), 32'(8 * (k > 4 ? 3 : k - 1)));
            if (k == 1)
            begin
                chk("irq", {31'h0, irq}, 32'h1);
                wr(ARS_ADDR_IRQ_STAT, 32'h7, ARS_RESP_OKAY);
                wr(ARS_ADDR_IRQ_MASK, 32'h4, ARS_RESP_OKAY);
                chk("irq clr", {31'h0, irq}, 32'h0);
            end
            // Single-contact wirings must give the same dead-time spacing
            if (k == 3 || k == 5)
                wr(ARS_ADDR_CTRL, k == 3 ? 32'h3 : 32'h5, ARS_RESP_OKAY);
        end
        flt();
        repeat (8) @(posedge clk);
        chk("block", {31'h0, dyn}, 32'h1);
        chk("irq blk", {31'h0, irq}, 32'h1);
        pug <= 1'b1;
        repeat (80) @(posedge clk);
        chk("blk hold", {31'h0, dyn}, 32'h1);
        pug <= 1'b0;
        repeat (80) @(posedge clk);
        chk("blk end", {31'h0, dyn}, 32'h0);
        $display("multi done");
    endtask : t_multi
    // Ground fault, no contacts, long close and pickup stretch restraint
    task automatic t_ground();
        wr(ARS_ADDR_CTRL, 32'h1, ARS_RESP_OKAY);
        wr(ARS_ADDR_T_MAX_CLOSE, 32'd150, ARS_RESP_OKAY);
        ph <= 4'h9;
        flt();
        shot(dt[1]);
        rd(ARS_ADDR_STATUS, d, ARS_RESP_OKAY);
        chk("gprog", {24'h0, d[7:0]}, 32'h8B);
        repeat (110) @(posedge clk);
        rd(ARS_ADDR_STATUS, d, ARS_RESP_OKAY);
        chk("ext close", {29'h0, d[2:0]}, 32'h3);
        pui <= 1'b1;
        repeat (100) @(posedge clk);
        rd(ARS_ADDR_STATUS, d, ARS_RESP_OKAY);
        chk("ext pickup", {29'h0, d[2:0]}, 32'h3);
        pui <= 1'b0;
        repeat (130) @(posedge clk);
        rd(ARS_ADDR_STATUS, d, ARS_RESP_OKAY);
        chk("reset", {25'h0, d[6:0]}, 32'h0);
        rd(ARS_ADDR_IRQ_STAT, d, ARS_RESP_OKAY);
        chk("irq ok", {31'h0, d[1]}, 32'h1);
        $display("ground done");
    endtask : t_ground
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_regs();
        t_multi();
        t_ground();
        end_of_test();
    end
endmodule : ars_top_test
`default_nettype wire
